// *** src/sfe_frame_status.sv ***
/*
  SPI frame checker and transfer error status register.
  Assumes the SPI decoder on clk supplies command, CRC, read and reset
  pulses and the driven output level; pins arrive asynchronously.
*/
// Summary of operation
// RQ1: Error flags latch high until register read
// RQ2: Read clears flag only if condition gone
// RQ3: Readout shows previous completed frame outcome
// RQ4: Under 24 rise or fall edges: short
// RQ5: Over 24 rise or fall edges: long
// RQ6: Driven output differs from feedback: output error
// RQ7: Invalid or undefined command sets command flag
// RQ8: Receive CRC failure sets CRC flag
// RQ9: Clock high at select fall: error
// RQ10: Clock high at select rise: error
// RQ11: Transfer aborted by reset event: flag
// RQ12: Flags zero from power-on reset
// RQ13: Register read-only, writes have no effect
// RQ14: Count edges in frame, check at end
`timescale 1ns/1ps
module sfe_frame_status
  import sfe_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_EDGES
) (
  // Clock and power-on reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Link pins, asynchronous to clk
  input  wire logic              sclkPin,
  input  wire logic              csPin_b,
  input  wire logic              sdoFeedbackPin,
  // Output driver state from the SPI shifter
  input  wire logic              sdoDrive,
  input  wire logic              sdoEnable,
  // Frame decoder events, one-cycle pulses on clk
  input  wire logic              cmdInvalid,
  input  wire logic              crcFail,
  input  wire logic              statusRead,
  input  wire logic              resetEvent,
  // Register value handed to the shifter for read-out
  output sfe_flags_t             statusValue,
  // Live flags, for diagnostics
  output sfe_flags_t             liveFlags,
  // Frame in progress
  output logic                   frameActive
);

  // Synchronised pins
  sfe_pins_t pinsSync;
  logic [2:0] pinsRaw;

  assign pinsRaw = {sclkPin, ~csPin_b, sdoFeedbackPin};

  // Chip select is inverted before sync so reset idles as deselected
  sfe_sync #(
    .WIDTH (3)
  ) uSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn (pinsRaw),
    .syncOut ({pinsSync.sclk, pinsSync.csActive, pinsSync.sdoFeedback})
  );

  logic selected;  // High while chip select pin is low
  assign selected = pinsSync.csActive;

  // Saturating increment, used for both edge counters
  function automatic logic [EDGE_CNT_W-1:0] satInc(
    input logic [EDGE_CNT_W-1:0] v
  );
    satInc = (v == EDGE_CNT_MAX) ? v : v + 1'b1;
  endfunction

  // Frame length compare against the nominal count
  function automatic logic lenBelow(input logic [EDGE_CNT_W-1:0] v);
    lenBelow = v < FRAME_LEN[EDGE_CNT_W-1:0];
  endfunction

  function automatic logic lenAbove(input logic [EDGE_CNT_W-1:0] v);
    lenAbove = v > FRAME_LEN[EDGE_CNT_W-1:0];
  endfunction

  // Edge tracking state
  logic                  sclkPrev_q, sclkPrev_d;   // Last sampled clock
  logic                  selPrev_q, selPrev_d;     // Last sampled select
  logic [EDGE_CNT_W-1:0] riseCnt_q, riseCnt_d;     // Rising edges
  logic [EDGE_CNT_W-1:0] fallCnt_q, fallCnt_d;     // Falling edges
  logic                  aborted_q, aborted_d;     // Frame cut by reset

  // Output comparison state
  logic [1:0]            drvDly_q, drvDly_d;       // Drive level delayed
  logic [1:0]            stable_q, stable_d;       // Cycles drive stable

  // Flag state
  sfe_flags_t            flags_q, flags_d;         // Live sticky flags
  sfe_flags_t            shown_q, shown_d;         // Snapshot for read-out
  logic                  active_q, active_d;       // Frame active copy

  // Decoded edges and per-frame events
  logic       sclkRise, sclkFall, selFall, selRise;
  logic       mismatch;
  sfe_flags_t setVec;    // Events raising flags this cycle
  sfe_flags_t present;   // Conditions still holding
  sfe_flags_t clearVec;  // Bits a read removes

  // Edge detection on synchronised pins
  always_comb begin
    sclkRise = pinsSync.sclk & ~sclkPrev_q;
    sclkFall = ~pinsSync.sclk & sclkPrev_q;
    selFall  = selected & ~selPrev_q;   // Chip select high to low
    selRise  = ~selected & selPrev_q;   // Chip select low to high
  end

  // Edge counters and abort tracking
  always_comb begin
    sclkPrev_d = pinsSync.sclk;
    selPrev_d  = selected;
    riseCnt_d  = riseCnt_q;
    fallCnt_d  = fallCnt_q;
    aborted_d  = aborted_q;
    if (selFall) begin
      // New frame restarts counting
      riseCnt_d = EDGE_CNT_RST;
      fallCnt_d = EDGE_CNT_RST;
      aborted_d = 1'b0;
    end else if (selected) begin
      // Count each polarity separately while selected
      if (sclkRise) begin
        riseCnt_d = satInc(riseCnt_q); // RQ14
      end
      if (sclkFall) begin
        fallCnt_d = satInc(fallCnt_q); // RQ14
      end
      if (resetEvent) begin
        // Cut frame: its edge counts no longer mean anything
        aborted_d = 1'b1;
      end
    end
  end

  // Output feedback compare; the delay matches the two sync stages,
  // and the settle wait avoids flagging the pin's own transition time
  always_comb begin
    drvDly_d = {drvDly_q[0], sdoDrive};
    if (drvDly_q[1] != drvDly_q[0]) begin
      stable_d = 2'h0;
    end else if (stable_q != SDO_SETTLE) begin
      stable_d = stable_q + 2'h1;
    end else begin
      stable_d = stable_q;
    end
    mismatch = selected & sdoEnable & (stable_q == SDO_SETTLE) &
               (drvDly_q[1] != pinsSync.sdoFeedback); // RQ6
  end

  // Event vector and still-present conditions
  always_comb begin
    setVec = '0;
    setVec.output_feedback_mismatch_flag  = mismatch; // RQ6
    // Length is judged only on a frame that ended normally
    setVec.short_frame_flag = selRise & ~aborted_q &
      (lenBelow(riseCnt_q) | lenBelow(fallCnt_q)); // RQ4
    setVec.long_frame_flag  = selRise & ~aborted_q &
      (lenAbove(riseCnt_q) | lenAbove(fallCnt_q)); // RQ5
    setVec.bad_command_flag               = cmdInvalid; // RQ7
    setVec.receive_crc_fail_flag          = crcFail; // RQ8
    setVec.clock_high_at_select_fall_flag = selFall & pinsSync.sclk; // RQ9
    setVec.clock_high_at_select_rise_flag = selRise & pinsSync.sclk; // RQ10
    setVec.reset_termination_flag         = selected & resetEvent; // RQ11
    // Only the output mismatch is a lasting level; others are events
    present = '0;
    present.output_feedback_mismatch_flag = mismatch;
  end

  // Sticky flags, snapshot and read clear
  always_comb begin
    // Only bits that were reported and are no longer present clear
    clearVec = statusRead ? (shown_q & ~present) : '0; // RQ2
    // A read while the cause persists leaves the flag standing
    // Set wins over clear in the same cycle
    flags_d  = (flags_q & ~clearVec) | setVec; // RQ1
    shown_d  = shown_q;
    if (selFall) begin
      // Capture at frame start so the read shows the prior frame
      shown_d = flags_q | setVec; // RQ3
    end
    active_d = selected;
  end

  // All state registers; power-on reset zeroes every flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkPrev_q <= 1'b0;
      selPrev_q  <= 1'b0;
      riseCnt_q  <= EDGE_CNT_RST;
      fallCnt_q  <= EDGE_CNT_RST;
      aborted_q  <= 1'b0;
      drvDly_q   <= 2'h0;
      stable_q   <= 2'h0;
      flags_q    <= sfe_flags_t'(STAT_RST); // RQ12
      shown_q    <= sfe_flags_t'(STAT_RST); // RQ12
      active_q   <= 1'b0;
    end else begin
      sclkPrev_q <= sclkPrev_d;
      selPrev_q  <= selPrev_d;
      riseCnt_q  <= riseCnt_d;
      fallCnt_q  <= fallCnt_d;
      aborted_q  <= aborted_d;
      drvDly_q   <= drvDly_d;
      stable_q   <= stable_d;
      flags_q    <= flags_d;
      shown_q    <= shown_d;
      active_q   <= active_d;
    end
  end

  // No write path exists: the register can only be read
  assign statusValue = shown_q; // RQ13
  // Live copy includes bits set since the last snapshot
  assign liveFlags   = flags_q;
  assign frameActive = active_q;

endmodule

// *** src/sfe_pkg.sv ***
/*
  Shared constants and types for the SPI frame error status block.
  Assumes a 24-clock SPI frame and an 8-bit status register.
*/
package sfe_pkg;

  // Frame length in clock edges of each polarity
  localparam int unsigned FRAME_EDGES = 24;
  // Edge counter width, wide enough to count past a full frame
  localparam int unsigned EDGE_CNT_W  = 6;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_MAX = 6'h3F;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RST = 6'h00;

  // Status register width and reset value
  localparam int unsigned STAT_W   = 8;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h00;

  // Status bit positions
  localparam int unsigned BIT_SDO_MISMATCH = 7;
  localparam int unsigned BIT_SHORT_FRAME  = 6;
  localparam int unsigned BIT_LONG_FRAME   = 5;
  localparam int unsigned BIT_BAD_COMMAND  = 4;
  localparam int unsigned BIT_CRC_FAIL     = 3;
  localparam int unsigned BIT_CLK_AT_FALL  = 2;
  localparam int unsigned BIT_CLK_AT_RISE  = 1;
  localparam int unsigned BIT_RESET_TERM   = 0;

  // Cycles the driven output must be stable before it is compared
  localparam logic [1:0] SDO_SETTLE = 2'h3;

  // Synchroniser stages
  localparam int unsigned SYNC_STAGES = 2;

  // Status flags, field order follows bit order 7..0
  typedef struct packed {
    logic output_feedback_mismatch_flag;
    logic short_frame_flag;
    logic long_frame_flag;
    logic bad_command_flag;
    logic receive_crc_fail_flag;
    logic clock_high_at_select_fall_flag;
    logic clock_high_at_select_rise_flag;
    logic reset_termination_flag;
  } sfe_flags_t;

  // Synchronised link pins
  typedef struct packed {
    logic sclk;
    logic csActive;
    logic sdoFeedback;
  } sfe_pins_t;

endpackage

// *** src/sfe_sync.sv ***
/*
  Two-flop level synchroniser for a bundle of asynchronous inputs.
  Assumes inputs are plain levels; pulses shorter than a clock are lost.
*/
`timescale 1ns/1ps
module sfe_sync
  import sfe_pkg::*;
#(
  parameter int unsigned WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage
  logic [WIDTH-1:0] sync_q;  // Second stage
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  // Next values of both stages
  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  // Stage registers; reset to zero, the caller picks idle polarity
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule

// *** sim/sfe_frame_status_asserts.sv ***
/* Port checker for the frame status block.
   Assumes a single clk domain; bound to the top below. */
`timescale 1ns/1ps
module sfe_asserts
  import sfe_pkg::*;
#(
  parameter int unsigned FRAME_LEN = FRAME_EDGES
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Link pins
  input wire logic       sclkPin,
  input wire logic       csPin_b,
  input wire logic       sdoFeedbackPin,
  // Driver state and events
  input wire logic       sdoDrive,
  input wire logic       sdoEnable,
  input wire logic       cmdInvalid,
  input wire logic       crcFail,
  input wire logic       statusRead,
  input wire logic       resetEvent,
  // Block outputs
  input wire sfe_flags_t statusValue,
  input wire sfe_flags_t liveFlags,
  input wire logic       frameActive
);
  // One domain, so shared clocking and disable
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Event pulses land one cycle later
  crc_set_a: assert property (crcFail |=> liveFlags[3])
    else $error("crc flag missed");
  cmd_set_a: assert property (cmdInvalid |=> liveFlags[4])
    else $error("cmd flag missed");
  // Selection in the event cycle shows on frameActive one cycle on
  term_set_a: assert property (
    resetEvent ##1 frameActive |-> liveFlags[0])
    else $error("abort flag missed");
  // Sticky until a read
  crc_hold_a: assert property (
    liveFlags[3] && !statusRead |=> liveFlags[3])
    else $error("crc flag dropped");
  no_false_a: assert property (
    !liveFlags[4] && !cmdInvalid |=> !liveFlags[4])
    else $error("cmd flag rose alone");
  // Read clears a shown bit whose cause is gone
  crc_clear_a: assert property (
    statusRead && statusValue[3] && !crcFail |=> !liveFlags[3])
    else $error("crc flag not cleared");
  // Snapshot moves only at frame start
  snap_hold_a: assert property (
    !$rose(frameActive) |-> $stable(statusValue))
    else $error("snapshot moved");
  snap_take_a: assert property (
    $rose(frameActive) |->
      statusValue[4] == $past(liveFlags[4] || cmdInvalid))
    else $error("snapshot wrong");
  // Main scenarios
  cover property ($rose(frameActive));
  cover property (statusRead && statusValue[6]);
  cover property ($rose(liveFlags[7]));
endmodule

bind sfe_frame_status sfe_asserts #(.FRAME_LEN(FRAME_LEN)) u_chk (
  .clk(clk), .rst_b(rst_b), .sclkPin(sclkPin), .csPin_b(csPin_b),
  .sdoFeedbackPin(sdoFeedbackPin), .sdoDrive(sdoDrive),
  .sdoEnable(sdoEnable), .cmdInvalid(cmdInvalid), .crcFail(crcFail),
  .statusRead(statusRead), .resetEvent(resetEvent),
  .statusValue(statusValue), .liveFlags(liveFlags),
  .frameActive(frameActive));

// *** sim/sfe_spi_ctrl.sv ***
/* SPI controller model that frames transfers on the link pins.
   Assumes the bench clk for pacing; sclk rests low between frames. */
`timescale 1ns/1ps
module sfe_spi_ctrl (
  // Bench clock, pacing only
  input  wire logic clk,
  // Level the device drives on its output
  input  wire logic sdoDrive,
  // Link pins
  output logic      sclkPin,
  output logic      csPin_b,
  output logic      sdoFeedbackPin
);
  logic fault; // Injected pin fault on the feedback
  initial begin
    sclkPin = 1'b0;
    csPin_b = 1'b1;
    fault = 1'b0;
  end
  // Feedback echoes the drive unless a fault is injected
  assign sdoFeedbackPin = sdoDrive ^ fault;
  // Inject or remove a fault on the feedback path
  task automatic set_fault(input logic f);
    fault = f;
  endtask
  // Wait k falling edges, so pins never move on the sampling edge
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Frame of n pulses at 200 ns; hf, hr give sclk at the cs edges
  task automatic frame(input int n, input logic hf, input logic hr);
    sclkPin = hf;
    wt(4);
    csPin_b = 1'b0;
    wt(4);
    sclkPin = 1'b0;
    repeat (n) begin
      wt(4);
      sclkPin = 1'b1;
      wt(4);
      sclkPin = 1'b0;
    end
    wt(4);
    sclkPin = hr;
    wt(4);
    csPin_b = 1'b1;
    wt(4);
    sclkPin = 1'b0;
    wt(8);
  endtask
endmodule

// *** sim/sfe_frame_status_tb_top.sv ***
/* Bench for the frame status block: frames from the controller
   model, event pulses from here. Assumes the bound checker. */
`timescale 1ns/1ps
module sfe_frame_status_tb_top
  import sfe_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       sdoDrive = 1'b0;
  logic       sdoEnable = 1'b0;
  logic [3:0] ev = 4'h0; // resetEvent, statusRead, crcFail, cmdInvalid
  logic       sclkPin, csPin_b, sdoFeedbackPin, frameActive;
  sfe_flags_t statusValue, liveFlags;
  int         n_errors = 0;
  int         total_checks = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  sfe_spi_ctrl u_mcu (.clk(clk), .sdoDrive(sdoDrive), .sclkPin(sclkPin),
    .csPin_b(csPin_b), .sdoFeedbackPin(sdoFeedbackPin));
  sfe_frame_status #(.FRAME_LEN(FRAME_EDGES)) u_dut (.clk(clk),
    .rst_b(rst_b), .sclkPin(sclkPin), .csPin_b(csPin_b),
    .sdoFeedbackPin(sdoFeedbackPin), .sdoDrive(sdoDrive),
    .sdoEnable(sdoEnable), .cmdInvalid(ev[0]), .crcFail(ev[1]),
    .statusRead(ev[2]), .resetEvent(ev[3]), .statusValue(statusValue),
    .liveFlags(liveFlags), .frameActive(frameActive));
  // Masked flag compare
  task automatic chk(input logic [7:0] g, m, e);
    total_checks++;
    if ((g & m) !== e) begin
      n_errors++;
      $display("Error at %0t: flags %h", $time, g);
    end
  endtask
  // Frame activity compare
  task automatic chk_act(input logic g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: frame active %b", $time, g);
    end
  endtask
  // One-cycle event pulse
  task automatic pulse(input logic [3:0] m);
    @(negedge clk) ev = m;
    @(negedge clk) ev = 4'h0;
  endtask
  // Good frame with events pulsed in mid-frame
  task automatic evframe(input logic [3:0] m);
    fork
      u_mcu.frame(24, 1'b0, 1'b0);
      begin
        u_mcu.wt(40);
        chk_act(frameActive, 1'b1);
        pulse(m);
      end
    join
  endtask
  task automatic t_init();
    chk(liveFlags, 8'hFF, 8'h00);
    chk(statusValue, 8'hFF, 8'h00);
    chk_act(frameActive, 1'b0);
    $display("t_init done");
  endtask
  task automatic t_len();
    u_mcu.frame(24, 1'b0, 1'b0);
    chk(liveFlags, 8'h60, 8'h00);
    u_mcu.frame(23, 1'b0, 1'b0);
    u_mcu.frame(24, 1'b0, 1'b0);
    chk(liveFlags, 8'h60, 8'h40);
    chk(statusValue, 8'h60, 8'h40);
    pulse(4'h4);
    chk(liveFlags, 8'h60, 8'h00);
    u_mcu.frame(25, 1'b0, 1'b0);
    chk(liveFlags, 8'h60, 8'h20);
    evframe(4'h4);
    chk(liveFlags, 8'h60, 8'h00);
    $display("t_len done");
  endtask
  // Clock high at either select edge; extra edges also flag length
  task automatic t_clk();
    u_mcu.frame(24, 1'b1, 1'b0);
    chk(liveFlags, 8'h06, 8'h04);
    evframe(4'h4);
    u_mcu.frame(24, 1'b0, 1'b1);
    chk(liveFlags, 8'h06, 8'h02);
    evframe(4'h4);
    chk(liveFlags, 8'hFF, 8'h00);
    $display("t_clk done");
  endtask
  // Aborted frame: length not judged
  task automatic t_evt();
    evframe(4'hB);
    chk(liveFlags, 8'h79, 8'h19);
    evframe(4'h4);
    chk(liveFlags, 8'hFF, 8'h00);
    $display("t_evt done");
  endtask
  // Power-on reset in mid-run clears flags and snapshot
  task automatic t_por();
    evframe(4'h3);
    u_mcu.frame(24, 1'b0, 1'b0);
    chk(statusValue, 8'hFF, 8'h18);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk(liveFlags, 8'hFF, 8'h00);
    chk(statusValue, 8'hFF, 8'h00);
    $display("t_por done");
  endtask
  // Feedback fault: ignored while undriven, survives a read
  task automatic t_sdo();
    sdoDrive = 1'b1;
    u_mcu.set_fault(1'b1);
    u_mcu.frame(24, 1'b0, 1'b0);
    chk(liveFlags, 8'h80, 8'h00);
    sdoEnable = 1'b1;
    u_mcu.frame(24, 1'b0, 1'b0);
    chk(liveFlags, 8'h80, 8'h80);
    evframe(4'h4);
    chk(liveFlags, 8'h80, 8'h80);
    u_mcu.set_fault(1'b0);
    evframe(4'h4);
    chk(liveFlags, 8'hFF, 8'h00);
    sdoEnable = 1'b0;
    $display("t_sdo done");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_init();
    t_len();
    t_clk();
    t_evt();
    t_por();
    t_sdo();
    close_out();
  end
  // Watchdog, about five times the expected run
  initial begin
    #500000;
    n_errors++;
    close_out();
  end
endmodule
